/* File: src/dual_adc_serial_power_control.sv */
// serial readout and power-mode control of a dual 12-bit converter
// Notes on behaviour
// (R1) early cut from normal enters partial power-down
// (R2) cut before second fall keeps normal mode
// (R3) long frame wakes; about one microsecond
// (R4) glitch frame in partial stays partial
// (R5) window cut in partial enters full power-down
// (R6) host may cut clocks when powering down
// (R7) host waits 1.5 ms after full wake
// (R8) short wake needs 67 us partial stay
// (R9) host runs dummy cycle after power-on
// (R10) host uses dummy cycle sequences for modes
// (R11) select fall: hold, sample, convert, drive lines
// (R12) after thirteenth fall, track on next rise
// (R13) sixteen clocks give two trailing zeros
// (R14) select rise ends frame, tri-states lines
// (R15) longer frame shifts other converter's result
// (R16) single-line read tri-states at 32nd fall
// (R17) two leading zeros then result MSB first
// (R18) last bit out on thirteenth fall
// (R19) host may capture on rising edges
// (R20) clock fall coincident with select fall ignored
// (R21) rise before first counted fall ignored
// (R22) cut after tenth fall stays powered, aborts
// (R23) fall counter; mode changes on select rise
// (R24) mode starts in normal after reset
`timescale 1ns/100ps
`include "dual_adc_regs.svh"
module dual_adc_serial_power_control
	import dual_adc_pkg::*;
#(parameter int FULL_WAKE_CYCLES = `FULL_WAKE_CYC) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// serial link pins
	input  wire logic        csN,
	input  wire logic        sclk,
	output logic             resultLineFirstOut,
	output logic             resultLineFirstOeN,
	output logic             resultLineSecondOut,
	output logic             resultLineSecondOeN,
	// converter core side
	input  wire logic [11:0] resultA,
	input  wire logic [11:0] resultB,
	output logic             holdSample,
	output logic             convStart,
	output logic             analogPowerOn,
	output logic             refPowerOn,
	output logic             powerGood,
	output power_mode_t      powerMode
);
	localparam int PART_WAKE_CYCLES = `PART_WAKE_CYC;
	edge_if ev ();
	// pin synchronisers and edge finder
	edge_sampler u_edges (
		.mclk (mclk),
		.rst  (rst),
		.csN  (csN),
		.sclk (sclk),
		.ev   (ev.src)
	);
	////////////////////////////////////////////////////////////////////
	// bit of one slot: two zeros, twelve bits MSB first, two zeros
	function automatic logic slotBit(input logic [11:0] d,
		input logic [5:0] n);
		logic [3:0] pos;
		pos = n[3:0];
		if (pos >= `POS_FIRST_BIT && pos <= `POS_LAST_BIT)
			slotBit = d[4'(`POS_LAST_BIT - pos)];
		else
			slotBit = 1'b0;
	endfunction
	////////////////////////////////////////////////////////////////////
	// frame state
	logic        active_r;     // frame in progress
	logic [5:0]  fallCnt_r;    // counted clock falls in this frame
	logic [11:0] capA_r;       // result of converter A
	logic [11:0] capB_r;       // result of converter B
	logic        outA_r;       // first line data bit
	logic        outB_r;       // second line data bit
	logic        oeN_r;        // both lines driven when low
	logic        hold_r;       // sample stage in hold
	logic        start_r;      // conversion start pulse
	logic        active_nxt;
	logic [5:0]  fallCnt_nxt;
	logic [11:0] capA_nxt;
	logic [11:0] capB_nxt;
	logic        outA_nxt;
	logic        outB_nxt;
	logic        oeN_nxt;
	logic        hold_nxt;
	logic        start_nxt;
	logic [5:0]  cntInc;       // counter after this fall
	logic        upper;        // second slot of a dual read
	// next frame state
	always_comb begin
		active_nxt  = active_r;
		fallCnt_nxt = fallCnt_r;
		capA_nxt    = capA_r;
		capB_nxt    = capB_r;
		outA_nxt    = outA_r;
		outB_nxt    = outB_r;
		oeN_nxt     = oeN_r;
		hold_nxt    = hold_r;
		start_nxt   = 1'b0;
		cntInc      = (fallCnt_r == `CNT_MAX) ? fallCnt_r : fallCnt_r + 6'h01;
		upper       = cntInc >= `CNT_SLOT;
		if (ev.csFall) begin
			// sample, start, drive first leading zero [R11] [R17]
			active_nxt  = 1'b1;
			fallCnt_nxt = 6'h00;
			capA_nxt    = resultA;
			capB_nxt    = resultB;
			outA_nxt    = 1'b0;
			outB_nxt    = 1'b0;
			oeN_nxt     = 1'b0;
			hold_nxt    = 1'b1;
			start_nxt   = 1'b1;
		end else if (ev.csRise) begin
			// end the frame and release lines [R14] [R22] [R1]
			active_nxt  = 1'b0;
			fallCnt_nxt = 6'h00; // [R23]
			oeN_nxt     = 1'b1;
			outA_nxt    = 1'b0;
			outB_nxt    = 1'b0;
		end else if (active_r && ev.csLow && ev.sclkFall) begin
			fallCnt_nxt = cntInc; // [R23]
			// lines swap converters in second slot [R15] [R13] [R18]
			outA_nxt = slotBit(upper ? capB_r : capA_r, cntInc);
			outB_nxt = slotBit(upper ? capA_r : capB_r, cntInc);
			if (cntInc == `CNT_DONE)
				oeN_nxt = 1'b1; // [R16]
		end else if (active_r && ev.sclkRise
			&& fallCnt_r >= `CNT_TRACK) begin
			hold_nxt = 1'b0; // [R12] [R21]
		end
	end
	// frame registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			active_r  <= 1'b0;
			fallCnt_r <= 6'h00;
			capA_r    <= 12'h000;
			capB_r    <= 12'h000;
			outA_r    <= 1'b0;
			outB_r    <= 1'b0;
			oeN_r     <= 1'b1;
			hold_r    <= 1'b0;
			start_r   <= 1'b0;
		end else begin
			active_r  <= active_nxt;
			fallCnt_r <= fallCnt_nxt;
			capA_r    <= capA_nxt;
			capB_r    <= capB_nxt;
			outA_r    <= outA_nxt;
			outB_r    <= outB_nxt;
			oeN_r     <= oeN_nxt;
			hold_r    <= hold_nxt;
			start_r   <= start_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////
	// power state
	power_mode_t mode_r;       // kept power mode
	logic        anaOn_r;      // analog supply enable
	logic        refOn_r;      // reference enable
	logic [17:0] wakeCnt_r;    // wake-up countdown
	logic        good_r;       // analog fully powered
	power_mode_t mode_nxt;
	logic        anaOn_nxt;
	logic        refOn_nxt;
	logic [17:0] wakeCnt_nxt;
	logic        good_nxt;
	logic        inWindow;     // cut between second and tenth fall
	// next power state
	always_comb begin
		mode_nxt    = mode_r;
		wakeCnt_nxt = wakeCnt_r;
		good_nxt    = good_r;
		inWindow    = fallCnt_r >= `CNT_WIN_OPEN
			&& fallCnt_r < `CNT_WIN_CLOSE;
		if (ev.csRise) begin
			// mode decided only at select rise [R23]
			if (fallCnt_r >= `CNT_WIN_CLOSE)
				mode_nxt = PWR_NORMAL; // [R3] [R22]
			else if (inWindow && mode_r == PWR_NORMAL)
				mode_nxt = PWR_PARTIAL; // [R1]
			else if (inWindow)
				mode_nxt = PWR_FULL; // [R5]
			else
				mode_nxt = mode_r; // [R2] [R4]
			if (mode_nxt != PWR_NORMAL) begin
				good_nxt    = 1'b0;
				wakeCnt_nxt = 18'h0_0000;
			end
		end else if (ev.csFall && mode_r != PWR_NORMAL) begin
			// power-up begins at select fall [R3]
			good_nxt    = 1'b0;
			wakeCnt_nxt = (mode_r == PWR_FULL) ? 18'(FULL_WAKE_CYCLES)
				: 18'(PART_WAKE_CYCLES);
		end else if (wakeCnt_r != 18'h0_0000) begin
			wakeCnt_nxt = wakeCnt_r - 18'h0_0001;
			good_nxt    = wakeCnt_r == 18'h0_0001;
		end else if (mode_r == PWR_NORMAL && !active_r) begin
			good_nxt = 1'b1;
		end
		// powered while in normal or while a frame may wake it [R4]
		anaOn_nxt = mode_nxt == PWR_NORMAL || (active_nxt && !ev.csRise);
		refOn_nxt = mode_nxt != PWR_FULL || (active_nxt && !ev.csRise);
	end
	// power registers; reset picks normal mode [R24]
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_r    <= PWR_NORMAL;
			anaOn_r   <= 1'b1;
			refOn_r   <= 1'b1;
			wakeCnt_r <= 18'h0_0000;
			good_r    <= 1'b1;
		end else begin
			mode_r    <= mode_nxt;
			anaOn_r   <= anaOn_nxt;
			refOn_r   <= refOn_nxt;
			wakeCnt_r <= wakeCnt_nxt;
			good_r    <= good_nxt;
		end
	end
	// outputs straight from flip-flops
	assign resultLineFirstOut  = outA_r;
	assign resultLineSecondOut = outB_r;
	assign resultLineFirstOeN  = oeN_r;
	assign resultLineSecondOeN = oeN_r;
	assign holdSample          = hold_r;
	assign convStart           = start_r;
	assign analogPowerOn       = anaOn_r;
	assign refPowerOn          = refOn_r;
	assign powerGood           = good_r;
	assign powerMode           = mode_r;
	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_enter_partial; // [R1]
		ev.csRise && mode_r == PWR_NORMAL && fallCnt_r >= 6'h02
			&& fallCnt_r <= 6'h09 |=> powerMode == PWR_PARTIAL;
	endproperty
	a_enter_partial: assert property (p_enter_partial) // [R1]
		else $error("window cut from normal missed partial");
	property p_stay_normal; // [R2]
		ev.csRise && mode_r == PWR_NORMAL && fallCnt_r < 6'h02
			|=> powerMode == PWR_NORMAL;
	endproperty
	a_stay_normal: assert property (p_stay_normal) // [R2]
		else $error("early cut left normal mode");
	property p_wake; // [R3]
		ev.csRise && fallCnt_r >= 6'h0a |=> powerMode == PWR_NORMAL;
	endproperty
	a_wake: assert property (p_wake) // [R3]
		else $error("long frame did not wake");
	property p_glitch_partial; // [R4]
		ev.csRise && mode_r == PWR_PARTIAL && fallCnt_r < 6'h02
			|=> powerMode == PWR_PARTIAL && !analogPowerOn;
	endproperty
	a_glitch_partial: assert property (p_glitch_partial) // [R4]
		else $error("glitch frame changed partial mode");
	property p_enter_full; // [R5]
		ev.csRise && mode_r == PWR_PARTIAL && fallCnt_r >= 6'h02
			&& fallCnt_r <= 6'h09 |=> powerMode == PWR_FULL;
	endproperty
	a_enter_full: assert property (p_enter_full) // [R5]
		else $error("window cut from partial missed full");
	property p_frame_start; // [R11]
		ev.csFall |=> holdSample && convStart && !resultLineFirstOeN
			&& !resultLineFirstOut ##1 !convStart;
	endproperty
	a_frame_start: assert property (p_frame_start) // [R11]
		else $error("select fall did not start frame");
	property p_track; // [R12]
		active_r && !ev.csFall && !ev.csRise && !ev.sclkFall
			&& ev.sclkRise && fallCnt_r == 6'h0d |=> !holdSample;
	endproperty
	a_track: assert property (p_track) // [R12]
		else $error("stage did not return to track");
	property p_rise_tristate; // [R14]
		ev.csRise |=> resultLineFirstOeN && resultLineSecondOeN;
	endproperty
	a_rise_tristate: assert property (p_rise_tristate) // [R14]
		else $error("lines driven after select rise");
	property p_done_32; // [R16]
		active_r && !ev.csFall && !ev.csRise && ev.sclkFall
			&& fallCnt_r == 6'h1f |=> resultLineFirstOeN;
	endproperty
	a_done_32: assert property (p_done_32) // [R16]
		else $error("line still driven after 32nd fall");
	property p_mode_hold; // [R23]
		!ev.csRise |=> $stable(powerMode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) // [R23]
		else $error("mode changed without select rise");
endmodule

/* File: src/dual_adc_regs.svh */
// constants for the dual converter serial readout and power control
`ifndef DUAL_ADC_REGS_SVH
`define DUAL_ADC_REGS_SVH

// serial clock falling-edge counts: power windows, track, slot, end of read, limit
`define CNT_WIN_OPEN    6'h02
`define CNT_WIN_CLOSE   6'h0a
`define CNT_TRACK       6'h0d
`define CNT_SLOT        6'h10
`define CNT_DONE        6'h20
`define CNT_MAX         6'h3f

// result layout inside one sixteen-clock slot
`define POS_FIRST_BIT   4'h2
`define POS_LAST_BIT    4'h0d

// timing: system clock rate and wake-up times
`define MCLK_MHZ        100
`define PART_WAKE_NS    1000
`define FULL_WAKE_US    1500
`define PART_WAKE_CYC   ((`PART_WAKE_NS * `MCLK_MHZ + 999) / 1000)
`define FULL_WAKE_CYC   (`FULL_WAKE_US * `MCLK_MHZ)

`endif

/* File: src/dual_adc_pkg.sv */
// types shared by the dual converter control modules
package dual_adc_pkg;
	// power state kept between frames
	typedef enum logic [1:0] {
		PWR_NORMAL,
		PWR_PARTIAL,
		PWR_FULL
	} power_mode_t;
endpackage

/* File: src/edge_if.sv */
// edge events of the frame select and serial clock pins
`timescale 1ns/100ps
interface edge_if;
	logic csFall;   // frame select went low
	logic csRise;   // frame select went high
	logic csLow;    // synchronised frame select level is low
	logic sclkFall; // counted serial clock falling edge
	logic sclkRise; // serial clock rising edge
	modport src (output csFall, csRise, csLow, sclkFall, sclkRise);
	modport dst (input csFall, csRise, csLow, sclkFall, sclkRise);
endinterface

/* File: src/edge_sampler.sv */
// pin synchroniser and edge finder for frame select and serial clock
`timescale 1ns/100ps
module edge_sampler (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// pins
	input  wire logic csN,
	input  wire logic sclk,
	// events
	edge_if.src       ev
);
	logic [1:0] csSync_r;   // two-stage synchroniser for frame select
	logic [1:0] sclkSync_r; // two-stage synchroniser for serial clock
	logic       csDly_r;    // previous synchronised frame select
	logic       sclkDly_r;  // previous synchronised serial clock
	logic [1:0] csSync_nxt;
	logic [1:0] sclkSync_nxt;

	////////////////////////////////////////////////////////////////////
	// next values: shift in; only stage two feeds the edge logic
	always_comb begin
		csSync_nxt   = {csSync_r[0], csN};
		sclkSync_nxt = {sclkSync_r[0], sclk};
	end

	// registers, idle high so no edge fires out of reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			csSync_r   <= 2'h3;
			sclkSync_r <= 2'h3;
			csDly_r    <= 1'b1;
			sclkDly_r  <= 1'b1;
		end else begin
			csSync_r   <= csSync_nxt;
			sclkSync_r <= sclkSync_nxt;
			csDly_r    <= csSync_r[1];
			sclkDly_r  <= sclkSync_r[1];
		end
	end

	////////////////////////////////////////////////////////////////////
	// edge decode; a clock fall together with the select fall is dropped
	always_comb begin
		ev.csFall   = csDly_r & ~csSync_r[1];
		ev.csRise   = ~csDly_r & csSync_r[1];
		ev.csLow    = ~csSync_r[1];
		ev.sclkFall = sclkDly_r & ~sclkSync_r[1] & ~ev.csFall; // [R20]
		ev.sclkRise = ~sclkDly_r & sclkSync_r[1];
	end
endmodule

/* File: verif/host_port_model.sv */
// host serial port model: frames select and clock, captures both lines
`timescale 1ns/100ps
module host_port_model (
	// clock
	input  wire logic mclk,
	// link pins driven by the host
	output logic      csN,
	output logic      sclk,
	// data lines as the host sees them
	input  wire logic firstOut,
	input  wire logic firstOeN,
	input  wire logic secondOut,
	input  wire logic secondOeN,
	// spare monitor sampled with each bit
	input  wire logic probe
);
	logic capFirst  [0:63]; // first line level just before fall i
	logic capSecond [0:63]; // second line level just before fall i
	logic probeAt   [0:63]; // monitor level just before fall i
	logic riseFirst [0:63]; // first line level just before rise i
	logic lastFirst;        // last driven level of the first line
	logic lastSecond;       // last driven level of the second line
	logic seenFirst;        // first line level at the host
	logic seenSecond;       // second line level at the host

	////////////////////////////////////////////////////////////
	// a released line shows the inverse of its last driven level
	always_comb begin
		seenFirst  = firstOeN ? ~lastFirst : firstOut;
		seenSecond = secondOeN ? ~lastSecond : secondOut;
	end

	// remember what each line last drove
	always @(posedge mclk) begin
		if (firstOeN === 1'b0) begin
			lastFirst <= firstOut;
		end
		if (secondOeN === 1'b0) begin
			lastSecond <= secondOut;
		end
	end

	// link idles high, clock stands still between frames
	initial begin
		csN        = 1'b1;
		sclk       = 1'b1;
		lastFirst  = 1'b0;
		lastSecond = 1'b0;
	end

	////////////////////////////////////////////////////////////
	// one frame of n clock falls; frames may stop short
	task automatic frame(input int n, input bit coinc);
		int i;
		@(negedge mclk);
		csN <= 1'b0;
		// optional clock fall together with the select fall
		if (coinc) begin
			sclk <= 1'b0;
			repeat (4) @(negedge mclk);
			sclk <= 1'b1;
		end
		repeat (8) @(negedge mclk);
		for (i = 1; i <= n; i++) begin
			// capture on the falling edge, just before it
			capFirst[i]  = seenFirst;
			capSecond[i] = seenSecond;
			probeAt[i]   = probe;
			sclk <= 1'b0;
			repeat (4) @(negedge mclk);
			// slow-clock host may also capture on the rise
			riseFirst[i] = seenFirst;
			sclk <= 1'b1;
			repeat (4) @(negedge mclk);
		end
		csN <= 1'b1;
	endtask
endmodule

/* File: verif/dual_adc_serial_power_control_tb.sv */
// self-checking bench for the serial readout and power control
`timescale 1ns/100ps
module dual_adc_serial_power_control_tb;
	import dual_adc_pkg::*;
	logic        mclk;       // system clock
	logic        rst;        // synchronous reset
	logic        csN;        // frame select from the host
	logic        sclk;       // serial clock from the host
	logic        firstOut;   // first line value
	logic        firstOeN;   // first line enable, low drives
	logic        secondOut;  // second line value
	logic        secondOeN;  // second line enable, low drives
	logic [11:0] resA;       // converter A result
	logic [11:0] resB;       // converter B result
	logic        hold;       // sample stage in hold
	logic        convStart;  // conversion start pulse
	logic        anaOn;      // analog powered
	logic        refOn;      // reference powered
	logic        pwrGood;    // wake-up time elapsed
	power_mode_t pwrMode;    // power mode from the design
	power_mode_t mode;       // model of the power mode
	int          numErrors;  // mismatches
	int          nTests;     // comparisons
	int          starts;     // convStart pulses seen
	int          seed;       // random seed
	int          r;          // loop index

	////////////////////////////////////////////////////////////
	// clock and pulse counter
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (convStart === 1'b1) begin
			starts++;
		end
	end

	// design under test, full wake count shortened to 200 cycles
	dual_adc_serial_power_control #(.FULL_WAKE_CYCLES(200)) i_dut (
		.mclk(mclk), .rst(rst), .csN(csN), .sclk(sclk),
		.resultLineFirstOut(firstOut), .resultLineFirstOeN(firstOeN),
		.resultLineSecondOut(secondOut), .resultLineSecondOeN(secondOeN),
		.resultA(resA), .resultB(resB), .holdSample(hold),
		.convStart(convStart), .analogPowerOn(anaOn), .refPowerOn(refOn),
		.powerGood(pwrGood), .powerMode(pwrMode)
	);

	// host on the far side of the link
	host_port_model i_host (
		.mclk(mclk), .csN(csN), .sclk(sclk),
		.firstOut(firstOut), .firstOeN(firstOeN),
		.secondOut(secondOut), .secondOeN(secondOeN), .probe(hold)
	);

	////////////////////////////////////////////////////////////
	// compare one value and count it
	task automatic check(input string what, input logic [11:0] seen,
		input logic [11:0] exp);
		nTests++;
		if (seen !== exp) begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// print the counts and the verdict, then stop
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// expected bit k of a line: 16-bit slots, second slot swapped
	function automatic logic expBit(int k, logic [11:0] a,
		logic [11:0] b, bit second);
		int p;
		logic [11:0] v;
		p = k % 16;
		v = ((k / 16) % 2 == 1) ^ second ? b : a;
		return (p >= 2 && p <= 13) ? v[13 - p] : 1'b0;
	endfunction

	// mode after a select rise with n counted falls
	function automatic power_mode_t nextMode(power_mode_t m, int n);
		if (n >= 10) begin
			return PWR_NORMAL;
		end else if (n >= 2) begin
			return (m == PWR_NORMAL) ? PWR_PARTIAL : PWR_FULL;
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////
	// one frame with fresh results, then idle checks
	task automatic runFrame(input int n, input bit coinc);
		int k;
		int s0;
		logic expQ[$]; // expected first-line bit after each fall
		s0 = starts;
		resA = 12'($random(seed));
		resB = 12'($random(seed));
		for (k = 0; k < 32; k++) begin
			expQ.push_back(expBit(k, resA, resB, 0));
		end
		i_host.frame(n, coinc);
		check("oeAtRise", firstOeN, n >= 32);
		for (k = 1; k <= n && k <= 32; k++) begin
			check("first", i_host.capFirst[k], expQ.pop_front());
			if (k <= 31) begin
				check("firstRise", i_host.riseFirst[k], expQ[0]);
			end
			check("second", i_host.capSecond[k], expBit(k - 1, resA, resB, 1));
		end
		if (n >= 1) begin
			check("holdAtStart", i_host.probeAt[1], 1);
		end
		if (n >= 15) begin
			check("holdBefore13", i_host.probeAt[13], 1);
			check("trackAfter13", i_host.probeAt[15], 0);
		end
		mode = nextMode(mode, n);
		// idle long enough for either wake count
		repeat (250) @(negedge mclk);
		check("mode", pwrMode, mode);
		check("oeIdle", {firstOeN, secondOeN}, 2'b11);
		check("analogOn", anaOn, mode == PWR_NORMAL);
		check("refOn", refOn, mode != PWR_FULL);
		check("powerGood", pwrGood, mode == PWR_NORMAL);
		check("starts", starts - s0, 1);
	endtask

	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 68;
		rst = 1'b1;
		resA = 12'h000;
		resB = 12'h000;
		starts = 0;
		mode = PWR_NORMAL;
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		check("resetMode", pwrMode, PWR_NORMAL);
		check("resetOe", firstOeN, 1);
		runFrame(16, 0); // full dummy cycle first
		runFrame(1, 0);
		runFrame(5, 0);
		// long stay in partial power-down
		repeat (6700) @(negedge mclk);
		runFrame(1, 0);
		runFrame(9, 0);
		runFrame(12, 0); // wake from full power-down
		runFrame(2, 0);
		runFrame(10, 0);
		runFrame(32, 1);
		for (r = 0; r < 8; r++) begin
			runFrame(($random(seed) & 32'h0000_003f) % 34, $random(seed) & 1);
		end
		conclude();
	end

	// watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge mclk);
		numErrors++;
		conclude();
	end
endmodule
